/* File: dv/bbs_status_osc_tb.sv */
// self-checking bench for the battery-backed status and oscillator registers
`timescale 1ns/1ps
`default_nettype none
`include "bbs_cfg.svh"
module bbs_status_osc_tb;
    import bbs_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic battery_por_in = 1'b1;
    logic watchdog_reset_in = 1'b0;
    logic flash_program_active_in = 1'b0;
    logic [7:0] spb_addr_in = 8'h00;
    logic spb_wr_in = 1'b0;
    logic spb_rd_in = 1'b0;
    logic [7:0] spb_wdata_in = 8'h00;
    logic [7:0] spb_rdata_out;
    logic external_clock_select_out;
    logic slow_osc_enable_out;
    logic power_reset_irq_out;
    int err_total = 0;
    int num_checks = 0;

    bbs_status_osc i_bbs_status_osc (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .battery_por_in(battery_por_in),
        .watchdog_reset_in(watchdog_reset_in),
        .flash_program_active_in(flash_program_active_in),
        .spb_addr_in(spb_addr_in),
        .spb_wr_in(spb_wr_in),
        .spb_rd_in(spb_rd_in),
        .spb_wdata_in(spb_wdata_in),
        .spb_rdata_out(spb_rdata_out),
        .external_clock_select_out(external_clock_select_out),
        .slow_osc_enable_out(slow_osc_enable_out),
        .power_reset_irq_out(power_reset_irq_out)
    );

    initial forever #50 sys_clk_in = ~sys_clk_in;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED time=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // inputs move 10 ns after the edge so the design samples settled values
    task automatic bus(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        #10;
        spb_rd_in = rd;
        spb_wr_in = wr;
        spb_addr_in = a;
        spb_wdata_in = d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, 1'b1, a, d);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    // read data stands from the edge after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b1, 1'b0, a, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        check(spb_rdata_out, exp);
    endtask

    task automatic ev(input logic w, input logic f, input logic r, input logic p);
        @(posedge sys_clk_in);
        #10;
        watchdog_reset_in = w;
        flash_program_active_in = f;
        rst_in = r;
        battery_por_in = p;
    endtask

    // event and write-one-clear share exactly one edge
    task automatic race(input logic w, input logic f, input logic [7:0] d);
        bus(1'b0, 1'b1, `BBS_STAT_OFS, d);
        watchdog_reset_in = w;
        flash_program_active_in = f;
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        watchdog_reset_in = 1'b0;
        flash_program_active_in = 1'b0;
    endtask

    task automatic t_por_and_clear;
        rdc(`BBS_STAT_OFS, 8'h80);
        rdc(`BBS_CLK_OFS, 8'h00);
        check({6'h00, slow_osc_enable_out, external_clock_select_out}, 8'h00);
        check({7'h00, power_reset_irq_out}, 8'h01);
        wr(`BBS_STAT_OFS, 8'h00);
        rdc(`BBS_STAT_OFS, 8'h80);
        wr(`BBS_STAT_OFS, 8'h80);
        rdc(`BBS_STAT_OFS, 8'h00);
        check({7'h00, power_reset_irq_out}, 8'h00);
    endtask

    task automatic t_events;
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        rdc(`BBS_STAT_OFS, 8'h20);
        check({7'h00, power_reset_irq_out}, 8'h01);
        check({7'h00, slow_osc_enable_out}, 8'h00);
        wr(`BBS_STAT_OFS, 8'hdf);
        rdc(`BBS_STAT_OFS, 8'h20);
        wr(`BBS_STAT_OFS, 8'h20);
        rdc(`BBS_STAT_OFS, 8'h00);
        // flag was clear, so only a winning set can leave it high
        race(1'b0, 1'b1, 8'h40);
        rdc(`BBS_STAT_OFS, 8'h40);
        wr(`BBS_STAT_OFS, 8'h00);
        rdc(`BBS_STAT_OFS, 8'h40);
        wr(`BBS_STAT_OFS, 8'h40);
        rdc(`BBS_STAT_OFS, 8'h00);
        race(1'b1, 1'b0, 8'h20);
        rdc(`BBS_STAT_OFS, 8'h20);
        wr(`BBS_STAT_OFS, 8'h20);
        rdc(`BBS_STAT_OFS, 8'h00);
    endtask

    task automatic t_osc;
        wr(`BBS_CLK_OFS, 8'h01);
        wr(`BBS_CLK_OFS, 8'h03);
        check({7'h00, external_clock_select_out}, 8'h01);
        check({7'h00, slow_osc_enable_out}, 8'h01);
        wr(`BBS_CLK_OFS, 8'hfe);
        check({7'h00, external_clock_select_out}, 8'h00);
        rdc(`BBS_CLK_OFS, 8'h02);
        wr(`BBS_CLK_OFS, 8'h01);
        check({7'h00, slow_osc_enable_out}, 8'h00);
        wr(`BBS_CLK_OFS, 8'h03);
        rdc(`BBS_CLK_OFS, 8'h03);
    endtask

    task automatic t_resets;
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        ev(1'b0, 1'b0, 1'b1, 1'b0);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        check(spb_rdata_out, 8'h00);
        rdc(`BBS_STAT_OFS, 8'h20);
        check({7'h00, slow_osc_enable_out}, 8'h01);
        rdc(8'h08, 8'h00);
        wr(8'h08, 8'hff);
        rdc(`BBS_CLK_OFS, 8'h03);
        // battery reset also beats the pending watchdog flag
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        rdc(`BBS_CLK_OFS, 8'h00);
        rdc(`BBS_STAT_OFS, 8'h80);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // the whole run needs about 80 cycles
    initial
    begin
        #50000;
        err_total++;
        finish_test();
    end

    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        #10;
        rst_in = 1'b0;
        battery_por_in = 1'b0;
        t_por_and_clear();
        t_events();
        t_osc();
        t_resets();
        finish_test();
    end
endmodule
`default_nettype wire

/* File: rtl/bbs_cfg.svh */
// offsets, bit positions and reset patterns of the battery-backed register pair
`ifndef BBS_CFG_SVH
`define BBS_CFG_SVH
`define BBS_STAT_OFS 8'h00
`define BBS_CLK_OFS 8'h04
`define BBS_FLAG_LSB 5
`define BBS_FLAG_CNT 3
`define BBS_WDT_IDX 0
`define BBS_FLASH_IDX 1
`define BBS_BATRST_IDX 2
`define BBS_EXTERNAL_CLOCK_SELECT_BIT 0
`define BBS_OSCEN_BIT 1
`define BBS_STAT_RST 3'h4
`define BBS_CLK_RST 2'h0
`define BBS_ZERO_BYTE 8'h00
`endif

/* File: rtl/bbs_flag_bank.sv */
// three sticky write-one-to-clear event flags
`timescale 1ns/1ps
`default_nettype none
`include "bbs_cfg.svh"
module bbs_flag_bank
    import bbs_pkg::*;
(
    // clock
    input wire logic sys_clk_in,
    // register carrier
    bbs_reg_if.flag rif
);
    bbs_flags_t flags;
    bbs_flags_t next_flags;
    bbs_flags_t hw_set;
    localparam bbs_flags_t por_flags = `BBS_STAT_RST;

    assign hw_set = {1'b0, rif.flash_evt, rif.wdt_evt};

    genvar i;
    generate
        for (i = 0; i < `BBS_FLAG_CNT; i++)
        begin : g_flag
            always_comb
            begin
                if (rif.bat_por)
                    next_flags[i] = por_flags[i];
                // set beats clear so a same-cycle event is never lost
                else if (hw_set[i])
                    next_flags[i] = 1'b1;
                // only a one clears, a zero leaves the flag alone
                else if (rif.stat_wr && rif.wdata[`BBS_FLAG_LSB + i])
                    next_flags[i] = 1'b0;
                else
                    next_flags[i] = flags[i];
            end
        end
    endgenerate

    // no system reset here: contents must outlive standby power loss
    always_ff @(posedge sys_clk_in)
    begin
        flags <= next_flags;
    end

    assign rif.flags = flags;
endmodule
`default_nettype wire

/* File: rtl/bbs_osc_ctrl.sv */
// slow oscillator select and enable bits
`timescale 1ns/1ps
`default_nettype none
`include "bbs_cfg.svh"
module bbs_osc_ctrl
    import bbs_pkg::*;
(
    // clock
    input wire logic sys_clk_in,
    // register carrier
    bbs_reg_if.osc rif
);
    bbs_osc_t osc_ctl;
    bbs_osc_t next_osc_ctl;

    always_comb
    begin
        if (rif.bat_por)
            next_osc_ctl = `BBS_CLK_RST;
        // firmware write is the only way in, no hardware path sets enable
        else if (rif.clk_wr)
            next_osc_ctl = rif.wdata[1:0];
        else
            next_osc_ctl = osc_ctl;
    end

    // system reset deliberately absent so the oscillator keeps running
    always_ff @(posedge sys_clk_in)
    begin
        osc_ctl <= next_osc_ctl;
    end

    assign rif.osc_ctl = osc_ctl;
endmodule
`default_nettype wire

/* File: rtl/bbs_pkg.sv */
// types shared by the battery-backed register pair
package bbs_pkg;
    typedef logic [7:0] bbs_byte_t;
    typedef logic [2:0] bbs_flags_t;
    typedef logic [1:0] bbs_osc_t;
    typedef enum logic [1:0] {BBS_SEL_NONE, BBS_SEL_STAT, BBS_SEL_CLK} bbs_sel_e;
endpackage

/* File: rtl/bbs_reg_if.sv */
// internal carrier between the register decode and the two storage modules
`timescale 1ns/1ps
`default_nettype none
interface bbs_reg_if;
    import bbs_pkg::*;
    logic stat_wr;
    logic clk_wr;
    bbs_byte_t wdata;
    logic bat_por;
    logic wdt_evt;
    logic flash_evt;
    bbs_flags_t flags;
    bbs_osc_t osc_ctl;
    modport dec (output stat_wr, clk_wr, wdata, bat_por, wdt_evt, flash_evt,
                 input flags, osc_ctl);
    modport flag (input stat_wr, wdata, bat_por, wdt_evt, flash_evt, output flags);
    modport osc (input clk_wr, wdata, bat_por, output osc_ctl);
endinterface
`default_nettype wire

/* File: rtl/bbs_status_osc.sv */
// battery-backed power-fail status and slow oscillator enable registers
// Summary of operation
// - watchdog forced reset sets status bit 5.
// - bit 5 clears on firmware write of one or battery power-on reset; zero ignored.
// - flash program or erase indication sets status bit 6.
// - bit 6 clears on firmware write of one or battery power-on reset; zero ignored.
// - battery power-on reset sets bit 7 and clears bits 6 and 5.
// - bit 7 clears only on firmware write of one; zero ignored.
// - the three flags survive loss of standby supply and system reset.
// - select bit 0 high means single-ended clock on crystal output pin.
// - select bit 0 low, the default, means crystal across both pins.
// - enable bit 1 turns the slow oscillator off at zero, on at one.
// - enable cleared by battery power-on reset, kept through system reset.
// - only a firmware write can turn the slow oscillator on.
// - interrupt is registered: high the cycle after any flag is set, low the cycle after none are.
// - interrupt feeds the maskable power-fail source of aggregator group 23.
// - clock enable register resets to zero; bits 7 to 2 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "bbs_cfg.svh"
module bbs_status_osc
    import bbs_pkg::*;
(
    // clock and system reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // battery power-on reset, one or more cycles high
    input wire logic battery_por_in,
    // hardware events
    input wire logic watchdog_reset_in,
    input wire logic flash_program_active_in,
    // controller peripheral bus
    input wire logic [7:0] spb_addr_in,
    input wire logic spb_wr_in,
    input wire logic spb_rd_in,
    input wire logic [7:0] spb_wdata_in,
    output logic [7:0] spb_rdata_out,
    // oscillator control
    output logic external_clock_select_out,
    output logic slow_osc_enable_out,
    // interrupt toward the aggregator
    output logic power_reset_irq_out
);
    bbs_reg_if rif();

    bbs_sel_e sel;
    bbs_byte_t rdata;
    bbs_byte_t next_rdata;
    logic irq;
    logic next_irq;
    bbs_byte_t stat_view;
    bbs_byte_t clk_view;

    always_comb
    begin
        case (spb_addr_in)
            `BBS_STAT_OFS: sel = BBS_SEL_STAT;
            `BBS_CLK_OFS: sel = BBS_SEL_CLK;
            default: sel = BBS_SEL_NONE;
        endcase
    end

    assign rif.stat_wr = spb_wr_in && (sel == BBS_SEL_STAT);
    assign rif.clk_wr = spb_wr_in && (sel == BBS_SEL_CLK);
    assign rif.wdata = spb_wdata_in;
    assign rif.bat_por = battery_por_in;
    assign rif.wdt_evt = watchdog_reset_in;
    assign rif.flash_evt = flash_program_active_in;

    bbs_flag_bank u_flags (
        .sys_clk_in(sys_clk_in),
        .rif(rif.flag)
    );

    bbs_osc_ctrl u_osc (
        .sys_clk_in(sys_clk_in),
        .rif(rif.osc)
    );

    // low status bits and upper enable bits are reserved, read as zero
    assign stat_view = {rif.flags, 5'h00};
    assign clk_view = {6'h00, rif.osc_ctl};

    always_comb
    begin
        next_rdata = rdata;
        if (spb_rd_in)
        begin
            case (sel)
                BBS_SEL_STAT: next_rdata = stat_view;
                BBS_SEL_CLK: next_rdata = clk_view;
                default: next_rdata = `BBS_ZERO_BYTE;
            endcase
        end
        // level, not pulse: the aggregator does its own latching and masking
        next_irq = |rif.flags;
    end

    // irq not cleared by system reset, it must track flags that outlive it
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            rdata <= `BBS_ZERO_BYTE;
        else
            rdata <= next_rdata;
        irq <= next_irq;
    end

    assign spb_rdata_out = rdata;
    assign power_reset_irq_out = irq;
    assign external_clock_select_out = rif.osc_ctl[`BBS_EXTERNAL_CLOCK_SELECT_BIT];
    assign slow_osc_enable_out = rif.osc_ctl[`BBS_OSCEN_BIT];

    // checks
    wdt_flag_set_a: assert property (
        @(posedge sys_clk_in) watchdog_reset_in && !battery_por_in
        |=> rif.flags[`BBS_WDT_IDX])
        else $error("watchdog event did not set its flag");

    wdt_flag_hold_a: assert property (
        @(posedge sys_clk_in) rif.flags[`BBS_WDT_IDX] && !battery_por_in
        && !(rif.stat_wr && spb_wdata_in[`BBS_FLAG_LSB + `BBS_WDT_IDX])
        |=> rif.flags[`BBS_WDT_IDX])
        else $error("watchdog flag cleared without a write of one");

    flash_flag_set_a: assert property (
        @(posedge sys_clk_in) flash_program_active_in && !battery_por_in
        |=> rif.flags[`BBS_FLASH_IDX])
        else $error("flash activity did not set its flag");

    flash_flag_clear_a: assert property (
        @(posedge sys_clk_in) !battery_por_in && !flash_program_active_in
        && rif.stat_wr && spb_wdata_in[`BBS_FLAG_LSB + `BBS_FLASH_IDX]
        |=> !rif.flags[`BBS_FLASH_IDX])
        else $error("write of one did not clear flash flag");

    bat_default_a: assert property (
        @(posedge sys_clk_in) battery_por_in
        |=> stat_view == 8'h80 && clk_view == 8'h00)
        else $error("battery reset default pattern wrong");

    bat_flag_hold_a: assert property (
        @(posedge sys_clk_in) rif.flags[`BBS_BATRST_IDX]
        && !(rif.stat_wr && spb_wdata_in[`BBS_FLAG_LSB + `BBS_BATRST_IDX])
        |=> rif.flags[`BBS_BATRST_IDX])
        else $error("battery reset flag lost without a write of one");

    flags_sysrst_a: assert property (
        @(posedge sys_clk_in) rst_in && !battery_por_in && !spb_wr_in
        && !watchdog_reset_in && !flash_program_active_in
        |=> $stable(rif.flags))
        else $error("system reset disturbed the event flags");

    osc_write_a: assert property (
        @(posedge sys_clk_in) rif.clk_wr && !battery_por_in
        |=> slow_osc_enable_out == $past(spb_wdata_in[`BBS_OSCEN_BIT])
        && external_clock_select_out == $past(spb_wdata_in[`BBS_EXTERNAL_CLOCK_SELECT_BIT]))
        else $error("clock enable write not taken");

    osc_sysrst_a: assert property (
        @(posedge sys_clk_in) rst_in && !battery_por_in && !rif.clk_wr
        |=> $stable(rif.osc_ctl))
        else $error("system reset changed the oscillator bits");

    osc_fw_only_a: assert property (
        @(posedge sys_clk_in) $rose(slow_osc_enable_out)
        |-> $past(rif.clk_wr && spb_wdata_in[`BBS_OSCEN_BIT]))
        else $error("oscillator enabled without a firmware write");

    irq_track_a: assert property (
        @(posedge sys_clk_in) disable iff (battery_por_in)
        ##1 power_reset_irq_out == (|$past(rif.flags)))
        else $error("interrupt does not follow the flags");

    reserved_read_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        spb_rd_in && sel == BBS_SEL_CLK |=> spb_rdata_out[7:2] == 6'h00)
        else $error("reserved enable bits read non-zero");

    set_wins_a: assert property (
        @(posedge sys_clk_in) watchdog_reset_in && rif.stat_wr && !battery_por_in
        && spb_wdata_in[`BBS_FLAG_LSB + `BBS_WDT_IDX] |=> rif.flags[`BBS_WDT_IDX])
        else $error("same-cycle watchdog event was lost");

    flash_race_a: assert property (
        @(posedge sys_clk_in) flash_program_active_in && rif.stat_wr && !battery_por_in
        && spb_wdata_in[`BBS_FLAG_LSB + `BBS_FLASH_IDX] |=> rif.flags[`BBS_FLASH_IDX])
        else $error("same-cycle flash event was lost");

    wdt_flag_clear_a: assert property (
        @(posedge sys_clk_in) !battery_por_in && !watchdog_reset_in
        && rif.stat_wr && spb_wdata_in[`BBS_FLAG_LSB + `BBS_WDT_IDX]
        |=> !rif.flags[`BBS_WDT_IDX])
        else $error("write of one did not clear watchdog flag");

    flash_flag_hold_a: assert property (
        @(posedge sys_clk_in) rif.flags[`BBS_FLASH_IDX] && !battery_por_in
        && !(rif.stat_wr && spb_wdata_in[`BBS_FLAG_LSB + `BBS_FLASH_IDX])
        |=> rif.flags[`BBS_FLASH_IDX])
        else $error("flash flag cleared without a write of one");

    bat_flag_clear_a: assert property (
        @(posedge sys_clk_in) !battery_por_in && rif.stat_wr
        && spb_wdata_in[`BBS_FLAG_LSB + `BBS_BATRST_IDX]
        |=> !rif.flags[`BBS_BATRST_IDX])
        else $error("write of one did not clear battery reset flag");

    bat_por_only_a: assert property (
        @(posedge sys_clk_in) !rif.flags[`BBS_BATRST_IDX] && !battery_por_in
        |=> !rif.flags[`BBS_BATRST_IDX])
        else $error("battery reset flag set without a battery reset");

    por_flags_a: assert property (
        @(posedge sys_clk_in) battery_por_in
        |=> rif.flags == `BBS_STAT_RST)
        else $error("battery reset left a stale event flag");

    zero_write_a: assert property (
        @(posedge sys_clk_in) !battery_por_in && rif.stat_wr
        && spb_wdata_in[7:5] == 3'h0
        |=> (rif.flags | ~$past(rif.flags)) == 3'h7)
        else $error("write of zeros cleared an event flag");

    stat_read_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        spb_rd_in && sel == BBS_SEL_STAT |=> spb_rdata_out[7:5] == $past(rif.flags))
        else $error("status read does not show the flags");

    stat_low_zero_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        spb_rd_in && sel == BBS_SEL_STAT |=> spb_rdata_out[4:0] == 5'h00)
        else $error("reserved status bits read non-zero");

    clk_read_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        spb_rd_in && sel == BBS_SEL_CLK
        |=> spb_rdata_out[1:0] == $past(rif.osc_ctl))
        else $error("clock enable read does not show the bits");

    unmapped_read_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        spb_rd_in && sel == BBS_SEL_NONE |=> spb_rdata_out == 8'h00)
        else $error("unmapped read returned non-zero data");

    stray_write_a: assert property (
        @(posedge sys_clk_in) spb_wr_in && sel == BBS_SEL_NONE && !battery_por_in
        |=> $stable(rif.osc_ctl))
        else $error("unmapped write changed the oscillator bits");

    external_clock_select_set_a: assert property (
        @(posedge sys_clk_in) rif.clk_wr && !battery_por_in
        && spb_wdata_in[`BBS_EXTERNAL_CLOCK_SELECT_BIT] |=> external_clock_select_out)
        else $error("external clock select not set by write");

    external_clock_select_clear_a: assert property (
        @(posedge sys_clk_in) rif.clk_wr && !battery_por_in
        && !spb_wdata_in[`BBS_EXTERNAL_CLOCK_SELECT_BIT] |=> !external_clock_select_out)
        else $error("crystal mode not restored by write");

    external_clock_select_default_a: assert property (
        @(posedge sys_clk_in) battery_por_in |=> !external_clock_select_out)
        else $error("battery reset left external clock selected");

    osc_por_off_a: assert property (
        @(posedge sys_clk_in) battery_por_in |=> !slow_osc_enable_out)
        else $error("battery reset left the oscillator running");

    osc_on_write_a: assert property (
        @(posedge sys_clk_in) rif.clk_wr && !battery_por_in
        && spb_wdata_in[`BBS_OSCEN_BIT] |=> slow_osc_enable_out)
        else $error("write of one did not start the oscillator");

    osc_off_write_a: assert property (
        @(posedge sys_clk_in) rif.clk_wr && !battery_por_in
        && !spb_wdata_in[`BBS_OSCEN_BIT] |=> !slow_osc_enable_out)
        else $error("write of zero did not stop the oscillator");

    osc_hold_a: assert property (
        @(posedge sys_clk_in) !rif.clk_wr && !battery_por_in
        |=> $stable(rif.osc_ctl))
        else $error("oscillator bits moved without a write");

    irq_low_a: assert property (
        @(posedge sys_clk_in) disable iff (battery_por_in)
        rif.flags == 3'h0 |=> !power_reset_irq_out)
        else $error("interrupt high with all flags clear");

    irq_high_a: assert property (
        @(posedge sys_clk_in) disable iff (battery_por_in)
        rif.flags != 3'h0 |=> power_reset_irq_out)
        else $error("interrupt low with a flag set");

    irq_raise_c: cover property (
        @(posedge sys_clk_in) !power_reset_irq_out ##1 power_reset_irq_out);
    flag_clear_c: cover property (
        @(posedge sys_clk_in) rif.flags[`BBS_BATRST_IDX] ##1 !rif.flags[`BBS_BATRST_IDX]);
    osc_on_c: cover property (
        @(posedge sys_clk_in) $rose(slow_osc_enable_out));
    race_c: cover property (
        @(posedge sys_clk_in) flash_program_active_in && rif.stat_wr
        && spb_wdata_in[`BBS_FLAG_LSB + `BBS_FLASH_IDX]);
    wdt_race_c: cover property (
        @(posedge sys_clk_in) watchdog_reset_in && rif.stat_wr
        && spb_wdata_in[`BBS_FLAG_LSB + `BBS_WDT_IDX]);
endmodule
`default_nettype wire
